// >>> hwsr_pkg.sv
// Package holding register map and constants for the secondary status and tach mode bank.
package hwsr_pkg;
  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [7:0] ADDR_TEST_A    = 8'h98;
  localparam logic [7:0] ADDR_TEST_B    = 8'ha3;
  localparam logic [7:0] ADDR_TEST_C    = 8'ha4;
  localparam logic [7:0] ADDR_SEC_STS1  = 8'ha5;
  localparam logic [7:0] ADDR_SEC_STS2  = 8'ha6;
  localparam logic [7:0] ADDR_SEC_STS3  = 8'ha7;
  localparam logic [7:0] ADDR_FAN_MODE  = 8'hab;
  localparam logic [7:0] ADDR_TEST_D    = 8'had;
  localparam logic [7:0] ADDR_ZONE1_TOP = 8'hae;
  localparam logic [7:0] ADDR_ZONE3_TOP = 8'haf;
  localparam logic [7:0] ADDR_ZONE2_TOP = 8'hb3;
  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [7:0] RST_TEST_A   = 8'hf1;
  localparam logic [7:0] RST_TEST_B   = 8'h00;
  localparam logic [7:0] RST_TEST_C   = 8'h02;
  localparam logic [7:0] RST_TEST_D   = 8'h00;
  localparam logic [7:0] RST_STATUS   = 8'h00;
  localparam logic [7:0] RST_FAN_MODE = 8'h00;
  localparam logic [7:0] RST_TOP_TEMP = 8'h2d;
  // ************************************************************
  // Field layouts
  // ************************************************************
  localparam logic [7:0] STS1_SUMMARY_BIT = 8'h80;
  localparam logic [7:0] STS1_EVENT_MASK  = 8'h7f;
  localparam logic [7:0] STS2_VALID_MASK  = 8'hdd;
  localparam logic [7:0] STS3_VALID_MASK  = 8'h03;
  localparam logic [7:0] FAN_MODE_MASK    = 8'hfc;
  localparam int FAN1_MODE_POS = 6;
  localparam int FAN2_MODE_POS = 4;
  localparam int FAN3_MODE_POS = 2;
  typedef enum logic [1:0] {
    HWSR_TACH_NORMAL  = 2'b00,
    HWSR_LOCK_ACT_HI  = 2'b01,
    HWSR_LOCK_ACT_LO  = 2'b10,
    HWSR_TACH_UNDEF   = 2'b11
  } hwsr_fan_mode_t;
endpackage

// >>> hwsr_regs.sv
// Secondary status, fan sense mode, top temperature and test register bank.
`timescale 1ns/100ps
`default_nettype none
module hwsr_regs
  import hwsr_pkg::*;
(
  // Clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_srst,
  // Register port
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  // Control inputs
  input  wire logic       i_lock,
  input  wire logic       i_main_power_good,
  // Live event levels in status bit layout
  input  wire logic [7:0] i_evt1,
  input  wire logic [7:0] i_evt2,
  input  wire logic [7:0] i_evt3,
  // Outputs to the fan and temperature logic
  output hwsr_fan_mode_t  o_fan1_mode,
  output hwsr_fan_mode_t  o_fan2_mode,
  output hwsr_fan_mode_t  o_fan3_mode,
  output logic      [7:0] o_zone1_top,
  output logic      [7:0] o_zone2_top,
  output logic      [7:0] o_zone3_top
);

  logic [7:0] sts1_ff;
  logic [7:0] sts2_ff;
  logic [7:0] sts3_ff;
  logic [7:0] test_a_ff;
  logic [7:0] test_b_ff;
  logic [7:0] fan_mode_ff;
  logic [7:0] top1_ff;
  logic [7:0] top2_ff;
  logic [7:0] top3_ff;
  logic       pg_ff;
  logic       pg_rise;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;

  // Next status value: live events set, clears only where written one and event gone.
  function automatic logic [7:0] sts_next(input logic [7:0] cur, input logic [7:0] evt,
                                          input logic [7:0] clr, input logic [7:0] valid);
    sts_next = ((cur & ~(clr & ~evt)) | evt) & valid;
  endfunction

  // ************************************************************
  // Power good edge detect
  // ************************************************************
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      pg_ff <= 1'b0;
    end else begin
      pg_ff <= i_main_power_good;
    end
  end
  assign pg_rise = i_main_power_good & ~pg_ff;

  // ************************************************************
  // Secondary status registers
  // ************************************************************
  logic [7:0] clr1;
  logic [7:0] clr2;
  logic [7:0] clr3;
  logic [7:0] ev1;
  assign clr1 = (i_wr && i_addr == ADDR_SEC_STS1) ? i_wdata : 8'h00;
  assign clr2 = (i_wr && i_addr == ADDR_SEC_STS2) ? i_wdata : 8'h00;
  assign clr3 = (i_wr && i_addr == ADDR_SEC_STS3) ? i_wdata : 8'h00;
  // Summary bit follows whether anything is latched in the second register.
  assign ev1 = (i_evt1 & STS1_EVENT_MASK) | ((|sts2_ff) ? STS1_SUMMARY_BIT : 8'h00);

  always_ff @(posedge i_ref_clk) begin
    if (i_srst || pg_rise) begin
      sts1_ff <= RST_STATUS;
      sts2_ff <= RST_STATUS;
      sts3_ff <= RST_STATUS;
    end else begin
      // Summary bit excluded from clear; set wins over clear.
      sts1_ff <= (sts_next(sts1_ff, ev1, clr1 & STS1_EVENT_MASK, STS1_EVENT_MASK)
                  | (ev1 & STS1_SUMMARY_BIT));
      sts2_ff <= sts_next(sts2_ff, i_evt2, clr2, STS2_VALID_MASK);
      sts3_ff <= sts_next(sts3_ff, i_evt3, clr3, STS3_VALID_MASK);
    end
  end
  // No interrupt output is produced from these registers.

  // ************************************************************
  // Test registers
  // ************************************************************
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      test_a_ff <= RST_TEST_A;
    end else if (i_wr && i_addr == ADDR_TEST_A && !i_lock) begin
      test_a_ff <= i_wdata;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      test_b_ff <= RST_TEST_B;
    end else if (i_wr && i_addr == ADDR_TEST_B) begin
      test_b_ff <= i_wdata;
    end
  end

  // ************************************************************
  // Fan sense mode register
  // ************************************************************
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      fan_mode_ff <= RST_FAN_MODE;
    end else if (i_wr && i_addr == ADDR_FAN_MODE) begin
      fan_mode_ff <= i_wdata & FAN_MODE_MASK;
    end
  end
  assign o_fan1_mode = hwsr_fan_mode_t'(fan_mode_ff[FAN1_MODE_POS +: 2]);
  assign o_fan2_mode = hwsr_fan_mode_t'(fan_mode_ff[FAN2_MODE_POS +: 2]);
  assign o_fan3_mode = hwsr_fan_mode_t'(fan_mode_ff[FAN3_MODE_POS +: 2]);

  // ************************************************************
  // Top temperature limits
  // ************************************************************
  always_ff @(posedge i_ref_clk) begin
    if (i_srst || pg_rise) begin
      top1_ff <= RST_TOP_TEMP;
      top2_ff <= RST_TOP_TEMP;
      top3_ff <= RST_TOP_TEMP;
    end else if (i_wr) begin
      if (i_addr == ADDR_ZONE1_TOP) begin
        top1_ff <= i_wdata;
      end
      if (i_addr == ADDR_ZONE2_TOP) begin
        top2_ff <= i_wdata;
      end
      if (i_addr == ADDR_ZONE3_TOP) begin
        top3_ff <= i_wdata;
      end
    end
  end
  // Limits are handed to the minimum temperature adjust logic outside.
  assign o_zone1_top = top1_ff;
  assign o_zone2_top = top2_ff;
  assign o_zone3_top = top3_ff;

  // ************************************************************
  // Read path
  // ************************************************************
  always_comb begin
    nxt_rdata = 8'h00;
    if (i_rd) begin
      case (i_addr)
        ADDR_TEST_A:    nxt_rdata = test_a_ff;
        ADDR_TEST_B:    nxt_rdata = test_b_ff;
        ADDR_TEST_C:    nxt_rdata = RST_TEST_C;
        ADDR_SEC_STS1:  nxt_rdata = sts1_ff;
        ADDR_SEC_STS2:  nxt_rdata = sts2_ff;
        ADDR_SEC_STS3:  nxt_rdata = sts3_ff;
        ADDR_FAN_MODE:  nxt_rdata = fan_mode_ff;
        ADDR_TEST_D:    nxt_rdata = RST_TEST_D;
        ADDR_ZONE1_TOP: nxt_rdata = top1_ff;
        ADDR_ZONE2_TOP: nxt_rdata = top2_ff;
        ADDR_ZONE3_TOP: nxt_rdata = top3_ff;
        default:        nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end
  assign o_rdata = rdata_ff;

  // ************************************************************
  // Assertions
  // ************************************************************
  a_lock_blocks_write: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (i_wr && i_addr == ADDR_TEST_A && i_lock) |=> $stable(test_a_ff))
    else $error("locked test register changed");
  a_summary_ro: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (!pg_rise && sts2_ff != 8'h00) |=> sts1_ff[7])
    else $error("summary bit lost");
  a_sts1_active_holds: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (!pg_rise && (i_evt1 & STS1_EVENT_MASK) != 8'h00)
      |=> ((sts1_ff & $past(i_evt1) & STS1_EVENT_MASK) == ($past(i_evt1) & STS1_EVENT_MASK)))
    else $error("active event bit not set");
  a_sts2_clear: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (i_wr && i_addr == ADDR_SEC_STS2 && i_wdata == 8'hff && i_evt2 == 8'h00)
      |=> sts2_ff == 8'h00)
    else $error("status 2 not cleared");
  a_pg_reset: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (pg_rise && i_evt3 == 8'h00) |=> (sts3_ff == 8'h00 && top1_ff == RST_TOP_TEMP))
    else $error("power good reload missing");
  a_sts3_reserved: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (sts3_ff & ~STS3_VALID_MASK) == 8'h00 && (sts2_ff & ~STS2_VALID_MASK) == 8'h00)
    else $error("reserved status bit set");
  a_mode_low_zero: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (i_rd && i_addr == ADDR_FAN_MODE) |=> o_rdata[1:0] == 2'b00)
    else $error("mode low bits nonzero");
  a_top_write: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (i_wr && i_addr == ADDR_ZONE2_TOP && !pg_rise) |=> top2_ff == $past(i_wdata))
    else $error("top limit write lost");
  a_test_c_fixed: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (i_rd && i_addr == ADDR_TEST_C) |=> o_rdata == RST_TEST_C)
    else $error("test register c wrong");

  // ************************************************************
  // Test register checks
  // ************************************************************

  // An unlocked write lands in the register at 98h.
  a_lock_free_write: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (i_wr && i_addr == ADDR_TEST_A && !i_lock) |=> test_a_ff == $past(i_wdata))
    else $error("unlocked test register write lost");

  // A read of the register at 98h returns what it held at the read edge.
  a_lock_read_back: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (i_rd && i_addr == ADDR_TEST_A) |=> o_rdata == $past(test_a_ff))
    else $error("test register read back wrong");

  // Without a write to 98h the register keeps its value.
  a_test_a_hold: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    !(i_wr && i_addr == ADDR_TEST_A) |=> $stable(test_a_ff))
    else $error("test register changed without write");

  // The register at A3h stores whatever software writes, hazard or not.
  a_test_b_write: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (i_wr && i_addr == ADDR_TEST_B) |=> test_b_ff == $past(i_wdata))
    else $error("test register b write lost");

  // The register at ADh always reads its fixed value.
  a_test_d_fixed: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (i_rd && i_addr == ADDR_TEST_D) |=> o_rdata == RST_TEST_D)
    else $error("test register d wrong");

  // ************************************************************
  // Secondary status checks
  // ************************************************************

  // Written ones clear the first register's event bits once the events are gone.
  a_sts1_clear: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (i_wr && i_addr == ADDR_SEC_STS1 && i_wdata == 8'h7f && (i_evt1 & STS1_EVENT_MASK) == 8'h00
      && !pg_rise) |=> (sts1_ff & STS1_EVENT_MASK) == 8'h00)
    else $error("status 1 not cleared");

  // Written zeros leave every latched event bit of the first register set.
  a_sts1_zero_write: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (i_wr && i_addr == ADDR_SEC_STS1 && i_wdata == 8'h00 && !pg_rise)
      |=> ((sts1_ff & $past(sts1_ff) & STS1_EVENT_MASK) == ($past(sts1_ff) & STS1_EVENT_MASK)))
    else $error("status 1 bit lost on zero write");

  // The summary bit mirrors whether anything was latched in the second register.
  a_summary_tracks: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    !pg_rise |=> sts1_ff[7] == ($past(sts2_ff) != 8'h00))
    else $error("summary bit does not track status 2");

  // The summary bit drops once the second register is empty.
  a_summary_clear: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (!pg_rise && sts2_ff == 8'h00) |=> !sts1_ff[7])
    else $error("summary bit stuck");

  // Writing one to the summary bit cannot clear it.
  a_summary_write_one: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (i_wr && i_addr == ADDR_SEC_STS1 && i_wdata[7] && !pg_rise && sts2_ff != 8'h00)
      |=> sts1_ff[7])
    else $error("summary bit cleared by write");

  // A live event in the second register keeps its bit set.
  a_sts2_active_holds: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (!pg_rise && (i_evt2 & STS2_VALID_MASK) != 8'h00)
      |=> ((sts2_ff & $past(i_evt2) & STS2_VALID_MASK) == ($past(i_evt2) & STS2_VALID_MASK)))
    else $error("active status 2 bit not set");

  // A live event in the third register keeps its bit set.
  a_sts3_active_holds: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (!pg_rise && (i_evt3 & STS3_VALID_MASK) != 8'h00)
      |=> ((sts3_ff & $past(i_evt3) & STS3_VALID_MASK) == ($past(i_evt3) & STS3_VALID_MASK)))
    else $error("active status 3 bit not set");

  // Written ones clear the third register once its events are gone.
  a_sts3_clear: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (i_wr && i_addr == ADDR_SEC_STS3 && i_wdata == 8'hff && i_evt3 == 8'h00)
      |=> sts3_ff == 8'h00)
    else $error("status 3 not cleared");

  // Written zeros leave every latched bit of the second register set.
  a_sts2_zero_write: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (i_wr && i_addr == ADDR_SEC_STS2 && i_wdata == 8'h00 && !pg_rise)
      |=> ((sts2_ff & $past(sts2_ff)) == $past(sts2_ff)))
    else $error("status 2 bit lost on zero write");

  // The fan 1 speed event lands at bit 2 of the second register.
  a_fan1_event_bit: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (!pg_rise && i_evt2[2]) |=> sts2_ff[2])
    else $error("fan 1 speed event not latched");

  // Both diode faults land in the top two bits of the second register.
  a_diode_fault_bits: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (!pg_rise && i_evt2[7:6] == 2'b11) |=> sts2_ff[7:6] == 2'b11)
    else $error("diode fault not latched");

  // The battery event lands at bit 1 of the third register.
  a_battery_bit: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (!pg_rise && i_evt3[1]) |=> sts3_ff[1])
    else $error("battery event not latched");

  // Reserved bits of the second register stay zero after a write.
  a_sts2_reserved_write: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (i_wr && i_addr == ADDR_SEC_STS2) |=> (sts2_ff & ~STS2_VALID_MASK) == 8'h00)
    else $error("reserved status 2 bit set by write");

  // A power good edge empties all three status registers.
  a_pg_sts_reload: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    pg_rise |=> (sts1_ff == RST_STATUS && sts2_ff == RST_STATUS && sts3_ff == RST_STATUS))
    else $error("status not reloaded on power good");

  // ************************************************************
  // Fan sense mode checks
  // ************************************************************

  // The three mode fields store the written upper six bits.
  a_mode_store: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (i_wr && i_addr == ADDR_FAN_MODE) |=> fan_mode_ff[7:2] == $past(i_wdata[7:2]))
    else $error("mode fields not stored");

  // Fan 1 mode output follows the top field as written.
  a_mode_fan1_out: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (i_wr && i_addr == ADDR_FAN_MODE) |=> o_fan1_mode == hwsr_fan_mode_t'($past(i_wdata[7:6])))
    else $error("fan 1 mode output wrong");

  // Fan 3 mode output follows the lowest field as written.
  a_mode_fan3_out: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (i_wr && i_addr == ADDR_FAN_MODE) |=> o_fan3_mode == hwsr_fan_mode_t'($past(i_wdata[3:2])))
    else $error("fan 3 mode output wrong");

  // The two reserved mode bits are never stored.
  a_mode_low_store: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    fan_mode_ff[1:0] == 2'b00)
    else $error("reserved mode bits stored");

  // ************************************************************
  // Top temperature checks
  // ************************************************************

  // Zone 1 limit takes a written value.
  a_top_write_z1: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (i_wr && i_addr == ADDR_ZONE1_TOP && !pg_rise) |=> top1_ff == $past(i_wdata))
    else $error("zone 1 limit write lost");

  // Zone 3 limit takes a written value.
  a_top_write_z3: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (i_wr && i_addr == ADDR_ZONE3_TOP && !pg_rise) |=> top3_ff == $past(i_wdata))
    else $error("zone 3 limit write lost");

  // A power good edge reloads all three limits.
  a_pg_top_reload: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    pg_rise |=> (top1_ff == RST_TOP_TEMP && top2_ff == RST_TOP_TEMP && top3_ff == RST_TOP_TEMP))
    else $error("limits not reloaded on power good");

  // The adjust logic outside sees a written limit at once.
  a_limit_outputs: assert property (@(posedge i_ref_clk) disable iff (i_srst)
    (i_wr && i_addr == ADDR_ZONE3_TOP && !pg_rise) |=> o_zone3_top == $past(i_wdata))
    else $error("zone 3 limit output wrong");

endmodule
`default_nettype wire

// >>> hwsr_regs_tb_top.sv
// Self-checking testbench for the secondary status, fan sense mode and limit bank.
`timescale 1ns/100ps
`default_nettype none
module hwsr_regs_tb_top import hwsr_pkg::*;;
  logic           i_ref_clk, i_srst, i_wr, i_rd, i_lock, i_main_power_good;
  logic     [7:0] i_addr, i_wdata, i_evt1, i_evt2, i_evt3, o_rdata;
  logic     [7:0] o_zone1_top, o_zone2_top, o_zone3_top;
  hwsr_fan_mode_t o_fan1_mode, o_fan2_mode, o_fan3_mode;
  int             num_errors, n_tests;

  hwsr_regs DUT (
    .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_lock(i_lock),
    .i_main_power_good(i_main_power_good), .i_evt1(i_evt1), .i_evt2(i_evt2),
    .i_evt3(i_evt3), .o_fan1_mode(o_fan1_mode), .o_fan2_mode(o_fan2_mode),
    .o_fan3_mode(o_fan3_mode), .o_zone1_top(o_zone1_top), .o_zone2_top(o_zone2_top),
    .o_zone3_top(o_zone3_top)
  );

  // ************************************************************
  // Access tasks
  // ************************************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the read strobe, so sample there.
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_ref_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    @(negedge i_ref_clk);
    chk(o_rdata, exp);
  endtask

  task automatic ev(input logic [7:0] e1, input logic [7:0] e2, input logic [7:0] e3);
    @(posedge i_ref_clk);
    i_evt1 <= e1;
    i_evt2 <= e2;
    i_evt3 <= e3;
  endtask

  task automatic pg_pulse();
    @(posedge i_ref_clk);
    i_main_power_good <= 1'b0;
    @(posedge i_ref_clk);
    i_main_power_good <= 1'b1;
    @(posedge i_ref_clk);
    // The reload lands on this edge, so look at the outputs once they have settled.
    @(negedge i_ref_clk);
  endtask

  task automatic report_and_stop();
    $display("Errors %0d, checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ************************************************************
  // Clock, watchdog and test sequence
  // ************************************************************
  initial begin
    i_ref_clk = 1'b0;
    forever #12.5 i_ref_clk = ~i_ref_clk;
  end

  initial begin
    repeat (3000) @(posedge i_ref_clk);
    num_errors++;
    report_and_stop();
  end

  initial begin
    logic [1:0] f;
    {i_srst, i_main_power_good} = 2'b11;
    {i_wr, i_rd, i_lock} = 3'b000;
    {i_addr, i_wdata, i_evt1, i_evt2, i_evt3} = '0;
    {num_errors, n_tests} = '0;
    repeat (16) @(posedge i_ref_clk);
    i_srst <= 1'b0;
    rc(ADDR_TEST_A, 8'hf1);
    rc(ADDR_TEST_B, 8'h00);
    rc(ADDR_SEC_STS1, 8'h00);
    rc(ADDR_SEC_STS2, 8'h00);
    rc(ADDR_SEC_STS3, 8'h00);
    rc(ADDR_FAN_MODE, 8'h00);
    rc(ADDR_ZONE1_TOP, 8'h2d);
    rc(ADDR_ZONE2_TOP, 8'h2d);
    rc(ADDR_ZONE3_TOP, 8'h2d);
    wr(ADDR_TEST_C, 8'h5a);
    rc(ADDR_TEST_C, 8'h02);
    wr(ADDR_TEST_D, 8'h5a);
    rc(ADDR_TEST_D, 8'h00);
    wr(8'h99, 8'hff);
    rc(8'h99, 8'h00);
    // Lock guards the register at 98h only.
    i_lock <= 1'b1;
    wr(ADDR_TEST_A, 8'h3c);
    rc(ADDR_TEST_A, 8'hf1);
    wr(ADDR_TEST_B, 8'ha5);
    rc(ADDR_TEST_B, 8'ha5);
    i_lock <= 1'b0;
    wr(ADDR_TEST_A, 8'h3c);
    rc(ADDR_TEST_A, 8'h3c);
    for (int m = 0; m < 4; m++) begin
      f = m[1:0];
      wr(ADDR_FAN_MODE, {f, ~f, f ^ 2'b01, 2'b11});
      rc(ADDR_FAN_MODE, {f, ~f, f ^ 2'b01, 2'b00});
      chk({6'h00, o_fan1_mode}, {6'h00, f});
      chk({6'h00, o_fan2_mode}, {6'h00, ~f});
      chk({6'h00, o_fan3_mode}, {6'h00, f ^ 2'b01});
    end
    wr(ADDR_ZONE1_TOP, 8'h11);
    wr(ADDR_ZONE2_TOP, 8'h22);
    wr(ADDR_ZONE3_TOP, 8'h33);
    rc(ADDR_ZONE2_TOP, 8'h22);
    chk(o_zone1_top ^ o_zone2_top ^ o_zone3_top, 8'h00);
    chk(o_zone3_top, 8'h33);
    pg_pulse();
    chk(o_zone1_top & o_zone2_top & o_zone3_top, 8'h2d);
    rc(ADDR_ZONE1_TOP, 8'h2d);
    // Status: one burst of all events, then fan 1 speed event stays active.
    ev(8'hff, 8'hff, 8'hff);
    ev(8'h00, 8'h04, 8'h00);
    rc(ADDR_SEC_STS1, 8'hff);
    rc(ADDR_SEC_STS2, 8'hdd);
    rc(ADDR_SEC_STS3, 8'h03);
    wr(ADDR_SEC_STS1, 8'h00);
    rc(ADDR_SEC_STS1, 8'hff);
    wr(ADDR_SEC_STS1, 8'hff);
    rc(ADDR_SEC_STS1, 8'h80);
    wr(ADDR_SEC_STS2, 8'hff);
    rc(ADDR_SEC_STS2, 8'h04);
    rc(ADDR_SEC_STS1, 8'h80);
    ev(8'h00, 8'h00, 8'h00);
    wr(ADDR_SEC_STS2, 8'h04);
    wr(ADDR_SEC_STS3, 8'h02);
    rc(ADDR_SEC_STS2, 8'h00);
    rc(ADDR_SEC_STS3, 8'h01);
    rc(ADDR_SEC_STS1, 8'h00);
    ev(8'hff, 8'hff, 8'hff);
    ev(8'h00, 8'h00, 8'h00);
    pg_pulse();
    rc(ADDR_SEC_STS1, 8'h00);
    rc(ADDR_SEC_STS2, 8'h00);
    rc(ADDR_SEC_STS3, 8'h00);
    report_and_stop();
  end
endmodule
`default_nettype wire
